// [logic/qdsp_pkg.sv]
// Shared constants for the quad converter serial control block.
// Assumes both link ends import it whole.
package qdsp_pkg;
    // ************************************************************
    // Command word layout
    // ************************************************************
    localparam int CMD_BITS     = 16;
    localparam int CNT_W        = 5;
    localparam int DATA_W       = 12;
    localparam int CODE_W       = 10;
    localparam int NUM_CH       = 4;
    localparam int ADDR_HI_POS  = 15;
    localparam int ADDR_LO_POS  = 14;
    localparam int OP_HI_POS    = 13;
    localparam int OP_LO_POS    = 12;
    localparam logic [CNT_W-1:0]  CNT_LAST  = 5'h0F;
    localparam logic [1:0]        OP_WR_HOLD = 2'h0;
    localparam logic [1:0]        OP_WR_UPD  = 2'h1;
    localparam logic [1:0]        OP_WR_ALL  = 2'h2;
    localparam logic [1:0]        OP_PWRDN   = 2'h3;
    localparam logic [DATA_W-1:0] DATA_RST   = 12'h000;
    localparam logic [CODE_W-1:0] CODE_RST   = 10'h000;
    // ************************************************************
    // Output termination codes
    // ************************************************************
    localparam logic [1:0] TERM_NORMAL = 2'h0;
    localparam logic [1:0] TERM_HIZ    = 2'h1;
    localparam logic [1:0] TERM_LOW_R  = 2'h2;
    localparam logic [1:0] TERM_HIGH_R = 2'h3;
    // ************************************************************
    // Host timing
    // ************************************************************
    localparam int CLK_DIV_HALF = 1;
    localparam int DIV_W        = 2;
    localparam logic [DIV_W-1:0] DIV_LAST = 2'(CLK_DIV_HALF);
endpackage

// [logic/qdsp_link_if.sv]
// Three-wire serial write link between host and converter control.
// Assumes the host drives all three wires.
`timescale 1ns/1ps
`default_nettype none
interface qdsp_link_if;
    logic sync_n;
    logic sclk;
    logic sdata;
    modport host_mp (output sync_n, output sclk, output sdata);
    modport dev_mp  (input sync_n, input sclk, input sdata);
endinterface
`default_nettype wire

// [logic/qdsp_device.sv]
// Converter control end: shifts, decodes and executes command words.
// Assumes sclk is the link clock and idles low with sync_n high.
// How it works
// - Operation 11 powers down, no write
// - Power-down acts on all four channels
// - Address 00 or 11 means high impedance
// - 01 low resistor, 10 high resistor
// - Any power-down also asserts shutdown
// - Power-down keeps channel codes intact
// - Wake write may change its channels
// - Host idles sync high and data low
// - Byte hosts hold sync across bytes
// - Host sends most significant bit first
// - Host data valid at falling edge
// - Host raises sync after last byte
// - Rising-edge hosts need inverted clock
// - Word hosts send 16-bit active-low frames
// - Shift on falling edge, run at 16th
// - Early sync rise discards the word
// - Address, operation, then twelve data bits
// - Channels clear to zero at reset
`timescale 1ns/1ps
`default_nettype none
// ************************************************************
// One channel: holding register and live output code
// ************************************************************
module qdsp_chan_reg
    import qdsp_pkg::*;
(
    input  wire logic              link_clk_i,
    input  wire logic              rst_i,
    input  wire logic              wr_en_i,
    input  wire logic              upd_en_i,
    input  wire logic [CODE_W-1:0] code_i,
    output logic      [CODE_W-1:0] input_o,
    output logic      [CODE_W-1:0] live_o
);
    logic [CODE_W-1:0] inreg_reg;
    logic [CODE_W-1:0] inreg_next;
    logic [CODE_W-1:0] out_reg;
    logic [CODE_W-1:0] out_next;

    // No enable during power-down, so both codes survive it
    always_comb begin
        inreg_next = inreg_reg;
        out_next   = out_reg;
        if (wr_en_i) begin
            inreg_next = code_i;
        end
        // Update copies the holding value, new or kept
        if (upd_en_i) begin
            out_next = inreg_next;
        end
    end

    // Same falling edge as the shift stage; no crossing here
    always_ff @(negedge link_clk_i or posedge rst_i) begin
        if (rst_i) begin
            inreg_reg <= CODE_RST;
            out_reg   <= CODE_RST;
        end else begin
            inreg_reg <= inreg_next;
            out_reg   <= out_next;
        end
    end

    assign input_o = inreg_reg;
    assign live_o  = out_reg;
endmodule

module qdsp_device
    import qdsp_pkg::*;
(
    input  wire logic               rst_i,
    qdsp_link_if.dev_mp             link,
    output logic [CODE_W-1:0]       chan_code_o [NUM_CH],
    output logic [CODE_W-1:0]       chan_input_o [NUM_CH],
    output logic [1:0]              term_sel_o,
    output logic                    shutdown_o,
    output logic                    cmd_done_o
);
    // ************************************************************
    // Shift stage on falling sclk; sync_n high clears the frame
    // ************************************************************
    logic [CMD_BITS-1:0] shift_reg;
    logic [CMD_BITS-1:0] shift_next;
    logic [CNT_W-1:0]    cnt_reg;
    logic [CNT_W-1:0]    cnt_next;
    logic                exec;
    logic [CMD_BITS-1:0] word;

    // Async reset by sync_n makes an early rise drop the partial word
    logic frame_rst;
    assign frame_rst = rst_i | link.sync_n;

    always_comb begin
        shift_next = shift_reg;
        cnt_next   = cnt_reg;
        if (cnt_reg <= CNT_LAST) begin
            shift_next = {shift_reg[CMD_BITS-2:0], link.sdata};
            cnt_next   = cnt_reg + 5'h01;
        end
    end

    always_ff @(negedge link.sclk or posedge frame_rst) begin
        if (frame_rst) begin
            shift_reg <= '0;
            cnt_reg   <= '0;
        end else begin
            shift_reg <= shift_next;
            cnt_reg   <= cnt_next;
        end
    end

    // Executes exactly on the 16th falling edge, extra edges ignored
    assign exec = (cnt_reg == CNT_LAST) && !link.sync_n;
    assign word = {shift_reg[CMD_BITS-2:0], link.sdata};

    // ************************************************************
    // Channel registers and power-down state
    // ************************************************************
    logic [1:0]        term_reg;
    logic [1:0]        term_next;
    logic              sd_reg;
    logic              sd_next;
    logic              done_reg;
    logic              done_next;
    logic [NUM_CH-1:0] wr_en;
    logic              upd_en;
    logic [1:0]        addr;
    logic [1:0]        op;
    logic [CODE_W-1:0] code;

    // ************************************************************
    // Command decode
    // ************************************************************
    assign addr = {word[ADDR_HI_POS], word[ADDR_LO_POS]};
    assign op   = {word[OP_HI_POS], word[OP_LO_POS]};
    // Twelve data bits; the ten most significant form the code
    assign code = word[DATA_W-1:DATA_W-CODE_W];

    always_comb begin
        term_next = term_reg;
        done_next = 1'b0;
        wr_en     = '0;
        upd_en    = 1'b0;
        if (exec) begin
            done_next = 1'b1;
            if (op == OP_PWRDN) begin
                // Channel enables stay low, so wake resumes the codes
                if (addr == 2'h1) begin
                    term_next = TERM_LOW_R;
                end else if (addr == 2'h2) begin
                    term_next = TERM_HIGH_R;
                end else begin
                    term_next = TERM_HIZ;
                end
            end else begin
                term_next = TERM_NORMAL;
                if (op == OP_WR_ALL) begin
                    wr_en  = '1;
                    upd_en = 1'b1;
                end else begin
                    wr_en[addr] = 1'b1;
                    upd_en      = (op == OP_WR_UPD);
                end
            end
        end
        // Registered so shutdown moves on the same edge as term
        sd_next = (term_next != TERM_NORMAL);
    end

    always_ff @(negedge link.sclk or posedge rst_i) begin
        if (rst_i) begin
            term_reg <= TERM_NORMAL;
            sd_reg   <= 1'b0;
            done_reg <= 1'b0;
        end else begin
            term_reg <= term_next;
            sd_reg   <= sd_next;
            done_reg <= done_next;
        end
    end

    // ************************************************************
    // Four identical channels share the decoded code and update
    // ************************************************************
    for (genvar g = 0; g < NUM_CH; g++) begin : g_chan
        qdsp_chan_reg u_qdsp_chan_reg (
            .link_clk_i (link.sclk),
            .rst_i      (rst_i),
            .wr_en_i    (wr_en[g]),
            .upd_en_i   (upd_en),
            .code_i     (code),
            .input_o    (chan_input_o[g]),
            .live_o     (chan_code_o[g])
        );
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    assign term_sel_o   = term_reg;
    assign shutdown_o   = sd_reg;
    assign cmd_done_o   = done_reg;
endmodule
`default_nettype wire

// [logic/qdsp_host.sv]
// Host end: sends one 16-bit command per request, MSB first.
// Assumes requests come from logic on ref_clk_i.
`timescale 1ns/1ps
`default_nettype none
module qdsp_host
    import qdsp_pkg::*;
(
    input  wire logic                ref_clk_i,
    input  wire logic                rst_i,
    input  wire logic                req_valid_i,
    input  wire logic [CMD_BITS-1:0] req_word_i,
    output logic                     req_ready_o,
    qdsp_link_if.host_mp             link
);
    // ************************************************************
    // Frame sequencer; sclk idles low, data changes on rising edge
    // ************************************************************
    typedef enum logic [1:0] {QDSP_IDLE, QDSP_SHIFT, QDSP_CLOSE} qdsp_st_e;
    qdsp_st_e            st_reg,  st_next;
    logic [CMD_BITS-1:0] sh_reg,  sh_next;
    logic [CNT_W-1:0]    cnt_reg, cnt_next;
    logic [DIV_W-1:0]    div_reg, div_next;
    logic                sclk_reg, sclk_next;
    logic                sync_reg, sync_next;
    logic                tick;

    assign tick = (div_reg == DIV_LAST);

    always_comb begin
        st_next   = st_reg;
        sh_next   = sh_reg;
        cnt_next  = cnt_reg;
        sclk_next = sclk_reg;
        sync_next = sync_reg;
        div_next  = tick ? '0 : div_reg + 2'h1;
        case (st_reg)
            QDSP_IDLE: begin
                div_next = '0;
                if (req_valid_i) begin
                    st_next   = QDSP_SHIFT;
                    sh_next   = req_word_i;
                    sync_next = 1'b0;
                    cnt_next  = '0;
                end
            end
            QDSP_SHIFT: begin
                if (tick) begin
                    sclk_next = ~sclk_reg;
                    // Falling edge is the device sample point
                    if (sclk_reg) begin
                        cnt_next = cnt_reg + 5'h01;
                        if (cnt_reg == CNT_LAST) begin
                            st_next = QDSP_CLOSE;
                        end
                    end else if (cnt_reg != '0) begin
                        // Data moves half a period clear of the sample
                        sh_next = {sh_reg[CMD_BITS-2:0], 1'b0};
                    end
                end
            end
            QDSP_CLOSE: begin
                if (tick) begin
                    sync_next = 1'b1;
                    sh_next   = '0;
                    st_next   = QDSP_IDLE;
                end
            end
            default: st_next = QDSP_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            st_reg   <= QDSP_IDLE;
            sh_reg   <= '0;
            cnt_reg  <= '0;
            div_reg  <= '0;
            sclk_reg <= 1'b0;
            sync_reg <= 1'b1;
        end else begin
            st_reg   <= st_next;
            sh_reg   <= sh_next;
            cnt_reg  <= cnt_next;
            div_reg  <= div_next;
            sclk_reg <= sclk_next;
            sync_reg <= sync_next;
        end
    end

    assign req_ready_o  = (st_reg == QDSP_IDLE);
    assign link.sync_n  = sync_reg;
    assign link.sclk    = sclk_reg;
    assign link.sdata   = sh_reg[CMD_BITS-1];
endmodule
`default_nettype wire

// [verif/qdsp_link_asserts.sv]
// Checker for the host-to-device serial link and device outputs.
// Assumes tb_top instantiates it beside the host-to-device link.
`timescale 1ns/1ps
`default_nettype none
module qdsp_link_asserts
    import qdsp_pkg::*;
(
    input wire logic       ref_clk_i,
    input wire logic       rst_i,
    input wire logic       sync_n,
    input wire logic       sclk,
    input wire logic       sdata,
    input wire logic [1:0] term_sel_o,
    input wire logic       shutdown_o,
    input wire logic       cmd_done_o
);
    // ************************************************************
    // Edge count and shadow word
    // ************************************************************
    logic [4:0]  cnt_reg, cnt_next;
    logic [14:0] sh_reg, sh_next;
    logic        exec;
    logic [1:0]  pd_term;
    logic        pd_reg, pd_next;
    always_comb begin
        cnt_next = cnt_reg;
        sh_next  = sh_reg;
        if (cnt_reg != 5'h10) begin
            cnt_next = cnt_reg + 5'h01;
            sh_next  = {sh_reg[13:0], sdata};
        end
    end
    // Sync rise clears at once, as an aborted word must
    always_ff @(negedge sclk or posedge rst_i or posedge sync_n) begin
        if (rst_i || sync_n) begin
            cnt_reg <= 5'h00;
            sh_reg  <= 15'h0000;
        end else begin
            cnt_reg <= cnt_next;
            sh_reg  <= sh_next;
        end
    end
    assign exec    = !sync_n && cnt_reg == 5'h0F;
    assign pd_term = (sh_reg[14:13] == 2'h1) ? TERM_LOW_R :
                     (sh_reg[14:13] == 2'h2) ? TERM_HIGH_R : TERM_HIZ;
    // Own power-down flag, so shutdown is not checked against itself
    assign pd_next = exec ? (sh_reg[12:11] == OP_PWRDN) : pd_reg;
    always_ff @(negedge sclk or posedge rst_i) begin
        if (rst_i) begin
            pd_reg <= 1'b0;
        end else begin
            pd_reg <= pd_next;
        end
    end
    // ************************************************************
    // Properties
    // ************************************************************
    a_done_exec: assert property (@(negedge sclk) disable iff (rst_i)
        exec |=> cmd_done_o) else $error("done missing after edge 16");
    a_done_idle: assert property (@(negedge sclk) disable iff (rst_i)
        !sync_n && !exec |=> !cmd_done_o) else $error("done without word");
    a_pd_term: assert property (@(negedge sclk) disable iff (rst_i)
        exec && sh_reg[12:11] == OP_PWRDN |=> shutdown_o &&
        term_sel_o == $past(pd_term)) else $error("wrong termination");
    a_wake_normal: assert property (@(negedge sclk) disable iff (rst_i)
        exec && sh_reg[12:11] != OP_PWRDN |=> !shutdown_o &&
        term_sel_o == TERM_NORMAL) else $error("write left power-down");
    a_term_stable: assert property (@(negedge sclk) disable iff (rst_i)
        !exec |=> $stable(term_sel_o)) else $error("term moved");
    a_sd_term: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        shutdown_o == pd_reg) else $error("shutdown off");
    a_frame_start: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        $fell(sync_n) |-> !sclk ##[1:4] sclk) else $error("bad frame start");
    a_sclk_idle: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        sync_n |-> !sclk) else $error("clock runs outside frame");
    c_pd: cover property (@(negedge sclk) exec && sh_reg[12:11] == OP_PWRDN);
    c_wr: cover property (@(negedge sclk) exec && sh_reg[12:11] == OP_WR_ALL);
    c_end: cover property (@(posedge ref_clk_i) $rose(sync_n));
endmodule
`default_nettype wire

// [verif/tb_top.sv]
// Bench: host drives device over one link; a raw driver faults a second.
// Assumes the qdsp package, link and both ends compile first.
`timescale 1ns/1ps
`default_nettype none
module tb_top
    import qdsp_pkg::*;
;
    logic        ref_clk_i = 1'b0;
    logic        rst_i     = 1'b0;
    logic        req_valid_i = 1'b0;
    logic [15:0] req_word_i  = 16'h0000;
    logic        req_ready_o, sd_a, sd_b, done_a, done_b;
    logic [9:0]  code_a [NUM_CH], inp_a [NUM_CH], code_b [NUM_CH];
    logic [9:0]  m_code [NUM_CH], m_inp [NUM_CH];
    logic [1:0]  term_a, term_b, m_term;
    logic        m_sd;
    logic [82:0] exp_q [$], e;
    integer      seed = 80;
    int          n_fail = 0, total_checks = 0, cycles = 0;
    qdsp_link_if u_link();
    qdsp_link_if u_link_b();
    qdsp_host u_qdsp_host(.ref_clk_i(ref_clk_i), .rst_i(rst_i),
        .req_valid_i(req_valid_i), .req_word_i(req_word_i),
        .req_ready_o(req_ready_o), .link(u_link));
    qdsp_device u_qdsp_device(.rst_i(rst_i), .link(u_link),
        .chan_code_o(code_a), .chan_input_o(inp_a), .term_sel_o(term_a),
        .shutdown_o(sd_a), .cmd_done_o(done_a));
    qdsp_device u_qdsp_device_b(.rst_i(rst_i), .link(u_link_b),
        .chan_code_o(code_b), .chan_input_o(), .term_sel_o(term_b),
        .shutdown_o(sd_b), .cmd_done_o(done_b));
    qdsp_link_asserts u_qdsp_link_asserts(.ref_clk_i(ref_clk_i),
        .rst_i(rst_i), .sync_n(u_link.sync_n), .sclk(u_link.sclk),
        .sdata(u_link.sdata), .term_sel_o(term_a), .shutdown_o(sd_a),
        .cmd_done_o(done_a));
    // ************************************************************
    // Tasks
    // ************************************************************
    task automatic chk(input string nm, input logic [11:0] s, x);
        total_checks++;
        if (s !== x) begin
            n_fail++;
            $display("MISMATCH %s exp %h seen %h", nm, x, s);
        end
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    // Model first, so the note queue keeps send order
    task automatic send(input logic [15:0] w);
        logic [82:0] n;
        if (w[13:12] == OP_PWRDN) begin
            m_term = (w[15:14] == 2'h1) ? TERM_LOW_R :
                     (w[15:14] == 2'h2) ? TERM_HIGH_R : TERM_HIZ;
            m_sd = 1'b1;
        end else begin
            m_term = TERM_NORMAL;
            m_sd = 1'b0;
            for (int i = 0; i < NUM_CH; i++) begin
                if (w[13:12] == OP_WR_ALL || i == int'(w[15:14])) begin
                    m_inp[i] = w[11:2];
                end
            end
            if (w[13:12] != OP_WR_HOLD) m_code = m_inp;
        end
        n = {m_term, m_sd, 80'h0};
        for (int i = 0; i < NUM_CH; i++) begin
            n[i*10 +: 10] = m_code[i];
            n[40+i*10 +: 10] = m_inp[i];
        end
        exp_q.push_back(n);
        while (req_ready_o !== 1'b1) begin
            @(posedge ref_clk_i);
            #2;
        end
        req_valid_i = 1'b1;
        req_word_i  = w;
        @(posedge ref_clk_i);
        #2 req_valid_i = 1'b0;
    endtask
    // Clock stands low between frames; released data shows inverse
    task automatic raw(input logic [19:0] v, input int n);
        u_link_b.sync_n = 1'b0;
        for (int i = 0; i < n; i++) begin
            #12 u_link_b.sdata = v[19-i];
            #12 u_link_b.sclk = 1'b1;
            #24 u_link_b.sclk = 1'b0;
        end
        #24 u_link_b.sync_n = 1'b1;
        u_link_b.sdata = ~u_link_b.sdata;
        #48;
    endtask
    // ************************************************************
    // Clock, timeout, watcher and main sequence
    // ************************************************************
    initial forever #25 ref_clk_i = ~ref_clk_i;
    always @(posedge ref_clk_i) begin
        cycles++;
        if (cycles == 6000) begin
            n_fail++;
            wrap_up();
        end
    end
    always @(posedge done_a) begin
        #1;
        chk("note", 12'(exp_q.size() != 0), 12'h001);
        e = exp_q.pop_front();
        chk("term", 12'(term_a), 12'(e[82:81]));
        chk("shutdown", 12'(sd_a), 12'(e[80]));
        for (int i = 0; i < NUM_CH; i++) begin
            chk("code", 12'(code_a[i]), 12'(e[i*10 +: 10]));
            chk("input", 12'(inp_a[i]), 12'(e[40+i*10 +: 10]));
        end
    end
    initial begin
        u_link_b.sync_n = 1'b1;
        u_link_b.sclk = 1'b0;
        u_link_b.sdata = 1'b0;
        m_term = TERM_NORMAL;
        m_sd = 1'b0;
        for (int i = 0; i < NUM_CH; i++) m_code[i] = CODE_RST;
        m_inp = m_code;
        // Raised after time zero so every reset edge is seen
        #1 rst_i = 1'b1;
        repeat (5) @(posedge ref_clk_i);
        #2 rst_i = 1'b0;
        for (int i = 0; i < NUM_CH; i++) begin
            chk("reset", 12'(code_a[i]) | 12'(code_b[i]), 12'h000);
        end
        send(16'h2ABC);
        for (int a = 0; a < 4; a++) send({2'(a), OP_PWRDN, 12'h5A5});
        send({2'h1, OP_WR_HOLD, 12'h3F0});
        send({2'h2, OP_PWRDN, 12'h000});
        send({2'h3, OP_WR_UPD, 12'hFFF});
        for (int k = 0; k < 20; k++) send(16'($random(seed)));
        raw({16'h2ABC, 4'h5}, 20);
        chk("extra bits", 12'(code_b[3]), 12'h2AF);
        raw({16'h7000, 4'h0}, 15);
        raw({16'h1123, 4'h0}, 15);
        chk("abort", {code_b[0], term_b}, {10'h2AF, TERM_NORMAL});
        chk("abort done", 12'({sd_b, done_b}), 12'h000);
        for (int k = 0; k < 400 && exp_q.size() != 0; k++) begin
            @(posedge ref_clk_i);
        end
        chk("drained", 12'(exp_q.size()), 12'h000);
        wrap_up();
    end
endmodule
`default_nettype wire
